// *** fps_pkg.sv ***
// Shared constants and types of the flash program sequencer.
// Assumes one 50 MHz system clock and an 8-bit special function register port.
package fps_pkg;

  // ****************************************************************
  // Flash control register location, fields and reset value
  // ****************************************************************
  localparam logic [7:0] FLASH_CTRL_ADDR  = 8'hD1;  // SFR address of flash_control
  localparam logic [7:0] FLASH_CTRL_RESET = 8'h00;  // All zero after reset
  localparam int         BUSY_BIT         = 0;      // prog_busy_flag
  localparam int         SPACE_LSB        = 1;      // space_select low bit
  localparam int         SPACE_MSB        = 2;      // space_select high bit
  localparam int         MAP_BIT          = 3;      // latch_map_select
  localparam int         KEY_LSB          = 4;      // launch_key low bit
  localparam int         KEY_MSB          = 7;      // launch_key high bit

  // ****************************************************************
  // Launch key values and space encodings
  // ****************************************************************
  localparam logic [3:0] KEY_FIRST  = 4'h5;   // First write of the launch key
  localparam logic [3:0] KEY_SECOND = 4'hA;   // Second write of the launch key
  localparam logic [1:0] SPACE_USER = 2'h0;   // User array
  localparam logic [1:0] SPACE_XROW = 2'h1;   // Extra row
  localparam logic [1:0] SPACE_SEC  = 2'h2;   // Security byte
  localparam logic [1:0] SPACE_RSVD = 2'h3;   // Reserved, never launches

  // ****************************************************************
  // Array geometry and address windows
  // ****************************************************************
  localparam int          PAGE_BYTES  = 128;       // Bytes per page and per latch buffer
  localparam int          USER_PAGES  = 256;       // Pages of the larger user array
  localparam logic [15:0] XROW_BASE   = 16'hFF80;  // Extra row window start
  localparam logic [15:0] SEC_ADDR    = 16'h0000;  // Security byte address
  localparam logic [15:0] BOOT_BASE   = 16'hF800;  // Boot array window start
  localparam logic [7:0]  ERASED_BYTE = 8'hFF;     // Value of an erased location
  localparam logic [7:0]  SEC_RESET   = 8'hFF;     // Security byte before any write

  // ****************************************************************
  // Programming time
  // ****************************************************************
  localparam int PROG_TIME_MS = 10;                          // Erase and program time
  localparam int CLK_MHZ      = 50;                          // System clock rate
  localparam int TICK_CYCLES  = CLK_MHZ;                     // Clocks per 1 us tick
  localparam int PROG_TICKS   = PROG_TIME_MS * 1000;         // 1 us ticks per operation

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    PS_IDLE,   // Waiting for a launch
    PS_ERASE,  // Erasing loaded locations
    PS_WAIT,   // Waiting out the cell time
    PS_PROG,   // Writing loaded locations
    PS_DONE    // Clearing latches and busy
  } fps_prog_state_type;

endpackage

// *** fps_prog_timer.sv ***
// Programming time counter of the flash program sequencer.
// Assumes a start pulse from the sequencer on the same clock.
`timescale 1ns/100ps
module fps_prog_timer
  import fps_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES,  // Clocks per tick
  parameter int TICKS    = PROG_TICKS    // Ticks per operation
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  // Control
  input  wire logic start,
  output logic      done
);

  localparam int DW = $clog2(TICK_DIV + 1);
  localparam int TW = $clog2(TICKS + 1);

  logic [DW-1:0] divCnt_q;   // Prescaler count
  logic [TW-1:0] tickCnt_q;  // Ticks still to go
  logic          running_q;  // Timing in progress
  logic          tickEn;     // One-cycle tick enable

  assign tickEn = running_q && (divCnt_q == DW'(TICK_DIV - 1));

  // ****************************************************************
  // Prescaler: a slow enable keeps the long count narrow
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      divCnt_q <= '0;
    end else if (start || tickEn) begin
      divCnt_q <= '0;
    end else if (running_q) begin
      divCnt_q <= divCnt_q + DW'(1);
    end
  end

  // ****************************************************************
  // Tick counter and done pulse
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tickCnt_q <= '0;
      running_q <= 1'b0;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        tickCnt_q <= TW'(TICKS);
        running_q <= 1'b1;
      end else if (tickEn) begin
        // Last tick ends the run
        if (tickCnt_q == TW'(1)) begin
          running_q <= 1'b0;
          done      <= 1'b1;
        end
        tickCnt_q <= tickCnt_q - TW'(1);
      end
    end
  end

endmodule

// *** fps_flash_program_sequencer.sv ***
// Flash program sequencer: control register, column latches, launch key,
// erase and program walk, and code space read mapping.
// Assumes the core gives one-cycle SFR and data write strobes on sys_clk,
// and that the boot array answers bootRdAddr in the same cycle.
`timescale 1ns/100ps
module fps_flash_program_sequencer
  import fps_pkg::*;
#(
  parameter int PAGES     = USER_PAGES,  // User array pages
  parameter int PROG_TIME = PROG_TICKS   // 1 us ticks per operation
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // Special function register port
  input  wire logic        sfrWrEn,
  input  wire logic        sfrRdEn,
  input  wire logic [7:0]  sfrAddr,
  input  wire logic [7:0]  sfrWrData,
  output logic      [7:0]  sfrRdData,
  // Data space writes from the core
  input  wire logic        xWrEn,
  input  wire logic [15:0] xAddr,
  input  wire logic [7:0]  xWrData,
  // Data space writes passed to data memory
  output logic             dmemWrEn,
  output logic      [15:0] dmemAddr,
  output logic      [7:0]  dmemWrData,
  // Code space reads
  input  wire logic        codeRdEn,
  input  wire logic [15:0] codeAddr,
  output logic      [7:0]  codeRdData,
  // Boot array
  input  wire logic        bootArraySelect,
  output logic      [15:0] bootRdAddr,
  input  wire logic [7:0]  bootRdData,
  // Core status
  output logic             progBusy,
  output logic             cpuIdleReq
);

  localparam int UW = $clog2(PAGES * PAGE_BYTES);  // User array address width

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0]         userArray [PAGES*PAGE_BYTES];  // User array cells
  logic [7:0]         xrowArray [PAGE_BYTES];        // Extra row cells
  logic [7:0]         secByte_q;                     // Security byte
  logic [7:0]         latchData [PAGE_BYTES];        // Column latches
  logic [PAGE_BYTES-1:0] latchLoaded_q;              // Loaded latch map
  logic [8:0]         pageAddr_q;                    // Page of last latch write
  logic [7:1]         ctrl_q;                        // Software bits of control
  logic               busy_q;                        // prog_busy_flag
  logic               keyArmed_q;                    // First key half seen
  logic [1:0]         progSpace_q;                   // Space being programmed
  logic [6:0]         walkIdx_q;                     // Latch walk index
  fps_prog_state_type state_q;                       // Sequencer state
  logic               ctrlWr;                        // Write to flash_control
  logic               keyWr;                         // Key write accepted
  logic               launch;                        // Launch pulse
  logic               latchWr;                       // Data write to latches
  logic               timerStart;                    // Timer start pulse
  logic               timerDone;                     // Timer end pulse
  logic [UW-1:0]      userIdx;                       // Walk target in user array
  logic               userPageOk;                    // Page lies in the array

  // Address lies inside the user array
  function automatic logic inUser(input logic [15:0] a);
    inUser = 32'(a) < PAGES * PAGE_BYTES;
  endfunction

  // ****************************************************************
  // Decodes
  // ****************************************************************
  assign ctrlWr     = sfrWrEn && (sfrAddr == FLASH_CTRL_ADDR);
  assign keyWr      = ctrlWr && !busy_q;
  assign launch     = keyWr && keyArmed_q
                      && (sfrWrData[KEY_MSB:KEY_LSB] == KEY_SECOND)
                      && (sfrWrData[SPACE_MSB:SPACE_LSB] != SPACE_RSVD);
  assign latchWr    = xWrEn && ctrl_q[MAP_BIT] && !busy_q;
  assign timerStart = (state_q == PS_ERASE) && (walkIdx_q == 7'h7F);
  assign userIdx    = UW'({pageAddr_q[7:0], walkIdx_q});
  assign userPageOk = 32'(pageAddr_q) < PAGES;
  assign progBusy   = busy_q;
  assign cpuIdleReq = busy_q;
  assign bootRdAddr = codeAddr - BOOT_BASE;

  // ****************************************************************
  // Control register: software bits, reset to zero
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= FLASH_CTRL_RESET[7:1];
    end else if (ctrlWr) begin
      // Busy bit is not part of the write
      ctrl_q <= sfrWrData[7:1];
    end
  end

  // ****************************************************************
  // Launch key: 5 then A, anything else in between discards it
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      keyArmed_q <= 1'b0;
    end else if (keyWr) begin
      keyArmed_q <= (sfrWrData[KEY_MSB:KEY_LSB] == KEY_FIRST);
    end
  end

  // ****************************************************************
  // Busy flag: set at launch, cleared only by the sequencer
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_q      <= FLASH_CTRL_RESET[BUSY_BIT];
      progSpace_q <= SPACE_USER;
    end else if (launch) begin
      busy_q      <= 1'b1;
      progSpace_q <= sfrWrData[SPACE_MSB:SPACE_LSB];
    end else if (state_q == PS_DONE) begin
      busy_q      <= 1'b0;
    end
  end

  // ****************************************************************
  // Register read: registered one cycle after the strobe
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sfrRdData <= 8'h00;
    end else if (sfrRdEn && (sfrAddr == FLASH_CTRL_ADDR)) begin
      sfrRdData <= {ctrl_q, busy_q};
    end else begin
      sfrRdData <= 8'h00;
    end
  end

  // ****************************************************************
  // Sequencer: erase walk, timed wait, program walk, done
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q   <= PS_IDLE;
      walkIdx_q <= 7'h00;
    end else begin
      case (state_q)
        PS_IDLE: begin
          walkIdx_q <= 7'h00;
          if (launch) begin
            state_q <= PS_ERASE;
          end
        end
        PS_ERASE: begin
          walkIdx_q <= walkIdx_q + 7'h01;
          if (walkIdx_q == 7'h7F) begin
            state_q <= PS_WAIT;
          end
        end
        PS_WAIT: begin
          // Busy spans the whole cell time
          if (timerDone) begin
            state_q <= PS_PROG;
          end
        end
        PS_PROG: begin
          walkIdx_q <= walkIdx_q + 7'h01;
          if (walkIdx_q == 7'h7F) begin
            state_q <= PS_DONE;
          end
        end
        PS_DONE: begin
          state_q <= PS_IDLE;
        end
        default: begin
          state_q <= PS_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Column latches: loaded map and last page
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      latchLoaded_q <= '0;
      pageAddr_q    <= 9'h000;
    end else if (state_q == PS_DONE) begin
      // Programmed data leaves the latches empty for the next load
      latchLoaded_q <= '0;
    end else if (latchWr) begin
      latchLoaded_q[xAddr[6:0]] <= 1'b1;
      pageAddr_q                <= xAddr[15:7];
    end
  end

  // Latch data holds no reset; only loaded entries are ever used
  always_ff @(posedge sys_clk) begin
    if (latchWr) begin
      latchData[xAddr[6:0]] <= xWrData;
    end
  end

  // ****************************************************************
  // Array update: erase then program only loaded locations
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if ((state_q == PS_ERASE || state_q == PS_PROG) && latchLoaded_q[walkIdx_q]) begin
      case (progSpace_q)
        SPACE_USER: begin
          if (userPageOk) begin
            userArray[userIdx] <= (state_q == PS_ERASE) ? ERASED_BYTE
                                                        : latchData[walkIdx_q];
          end
        end
        SPACE_XROW: begin
          xrowArray[walkIdx_q] <= (state_q == PS_ERASE) ? ERASED_BYTE
                                                        : latchData[walkIdx_q];
        end
        default: begin
        end
      endcase
    end
  end

  // Security byte: software reaches the upper nibble only
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      secByte_q <= SEC_RESET;
    end else if (progSpace_q == SPACE_SEC && walkIdx_q == SEC_ADDR[6:0]
                 && latchLoaded_q[0]) begin
      if (state_q == PS_ERASE) begin
        secByte_q[7:4] <= ERASED_BYTE[7:4];
      end else if (state_q == PS_PROG) begin
        secByte_q[7:4] <= latchData[0][7:4];
      end
    end
  end

  // ****************************************************************
  // Data memory pass-through when latches are not mapped
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dmemWrEn   <= 1'b0;
      dmemAddr   <= 16'h0000;
      dmemWrData <= 8'h00;
    end else begin
      dmemWrEn <= xWrEn && !ctrl_q[MAP_BIT];
      if (xWrEn && !ctrl_q[MAP_BIT]) begin
        dmemAddr   <= xAddr;
        dmemWrData <= xWrData;
      end
    end
  end

  // ****************************************************************
  // Code space reads by mapped space; busy flash returns erased
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      codeRdData <= 8'h00;
    end else if (codeRdEn) begin
      codeRdData <= ERASED_BYTE;
      if (bootArraySelect && codeAddr >= BOOT_BASE) begin
        codeRdData <= bootRdData;
      end else if (!busy_q) begin
        case (ctrl_q[SPACE_MSB:SPACE_LSB])
          SPACE_USER: begin
            if (inUser(codeAddr)) begin
              codeRdData <= userArray[UW'(codeAddr)];
            end
          end
          SPACE_XROW: begin
            if (codeAddr >= XROW_BASE) begin
              codeRdData <= xrowArray[codeAddr[6:0]];
            end
          end
          SPACE_SEC: begin
            if (codeAddr == SEC_ADDR) begin
              codeRdData <= secByte_q;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Programming timer
  // ****************************************************************
  fps_prog_timer #(
    .TICK_DIV (TICK_CYCLES),
    .TICKS    (PROG_TIME)
  ) progTimer (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .start   (timerStart),
    .done    (timerDone)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_busy_on_launch: assert property (launch |=> busy_q && state_q == PS_ERASE)
    else $error("busy not set after launch");
  a_busy_sw_hold: assert property (busy_q && ctrlWr && state_q != PS_DONE |=> busy_q)
    else $error("software write cleared busy");
  a_key_order: assert property ($rose(keyArmed_q) |-> $past(keyWr)
                                && $past(sfrWrData[KEY_MSB:KEY_LSB]) == KEY_FIRST)
    else $error("launch without first key half");
  a_rsvd_space: assert property (keyWr && keyArmed_q && sfrWrData == 8'hA6 |=> !busy_q)
    else $error("reserved space launched");
  a_busy_ignore: assert property (busy_q |-> !launch ##1 $stable(keyArmed_q))
    else $error("key taken while busy");
  a_key_discard: assert property (keyWr && sfrWrData[7:4] != KEY_FIRST |=> !keyArmed_q)
    else $error("key not discarded");
  a_latch_page: assert property (latchWr |=> pageAddr_q == $past(xAddr[15:7])
                                 && latchLoaded_q[$past(xAddr[6:0])])
    else $error("latch write lost");
  a_map_pass: assert property (xWrEn && ctrl_q[MAP_BIT] |=> !dmemWrEn)
    else $error("mapped write reached data memory");
  a_erase_first: assert property ($rose(state_q == PS_WAIT) |-> $past(state_q) == PS_ERASE
                                  && busy_q)
    else $error("wait without erase");
  a_idle_req: assert property ($fell(busy_q) |-> $past(state_q) == PS_DONE
                               && !cpuIdleReq)
    else $error("busy ended outside done");

  c_user_launch: cover property (launch && sfrWrData[2:1] == SPACE_USER);
  c_xrow_launch: cover property (launch && sfrWrData[2:1] == SPACE_XROW);
  c_sec_launch:  cover property (launch && sfrWrData[2:1] == SPACE_SEC);
  c_busy_end:    cover property ($fell(busy_q));

endmodule

// *** fps_core_side.sv ***
// Far side model: boot array that answers the sequencer's boot read address.
// Assumes the sequencer samples bootRdData in the same cycle as the code read.
`timescale 1ns/100ps
module fps_core_side (
  // Boot array port
  input  wire logic [15:0] bootRdAddr,
  output logic      [7:0]  bootRdData
);
  // ****************************************************************
  // Boot array contents
  // ****************************************************************
  // Data follows the low offset byte, so a window base wrong in its low byte shows as wrong data
  assign bootRdData = bootRdAddr[7:0] ^ 8'hA5;
endmodule

// *** testbench.sv ***
// Self-checking bench of the flash program sequencer.
// Assumes a short programming time and four user pages, set at the instance.
`timescale 1ns/100ps
module testbench;
  import fps_pkg::*;
  // ****************************************************************
  // Signals, counters and load table
  // ****************************************************************
  logic        sys_clk, reset_n, sfrWrEn, sfrRdEn, xWrEn, codeRdEn, bootArraySelect;
  logic        dmemWrEn, progBusy, cpuIdleReq;
  logic [7:0]  sfrAddr, sfrWrData, sfrRdData, xWrData, dmemWrData, codeRdData, bootRdData, v;
  logic [15:0] xAddr, dmemAddr, codeAddr, bootRdAddr;
  int          miscompares, checkCount, cycles, n;
  // Mode, load address, data, expected read and read of 0100h per space
  logic [7:0]  ldMode  [3] = '{8'h08, 8'h0A, 8'h0C};
  logic [15:0] ldAddr  [3] = '{16'h0101, 16'hFF85, 16'h0000};
  logic [7:0]  ldData  [3] = '{8'h66, 8'h3C, 8'h5A};
  logic [7:0]  expData [3] = '{8'h66, 8'h3C, 8'h5F};
  logic [7:0]  rdOther [3] = '{8'h11, 8'hFF, 8'hFF};

  fps_flash_program_sequencer #(.PAGES(4), .PROG_TIME(5)) u_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn),
    .sfrAddr(sfrAddr), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .xWrEn(xWrEn),
    .xAddr(xAddr), .xWrData(xWrData), .dmemWrEn(dmemWrEn), .dmemAddr(dmemAddr),
    .dmemWrData(dmemWrData), .codeRdEn(codeRdEn), .codeAddr(codeAddr),
    .codeRdData(codeRdData), .bootArraySelect(bootArraySelect), .bootRdAddr(bootRdAddr),
    .bootRdData(bootRdData), .progBusy(progBusy), .cpuIdleReq(cpuIdleReq));
  fps_core_side u_core (.bootRdAddr(bootRdAddr), .bootRdData(bootRdData));

  // ****************************************************************
  // Clock, hang guard and access tasks
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Four operations need about 2100 cycles, so 5000 means a hang
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      closeOut();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checkCount++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic sfrWr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) #1;
    sfrWrEn = 1'b1;
    sfrAddr = a;
    sfrWrData = d;
    @(posedge sys_clk) #1;
    sfrWrEn = 1'b0;
  endtask
  task automatic sfrRd(input logic [7:0] a, output logic [7:0] r);
    @(posedge sys_clk) #1;
    sfrRdEn = 1'b1;
    sfrAddr = a;
    @(posedge sys_clk) #1;
    sfrRdEn = 1'b0;
    r = sfrRdData;
  endtask
  task automatic xWr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk) #1;
    xWrEn = 1'b1;
    xAddr = a;
    xWrData = d;
    @(posedge sys_clk) #1;
    xWrEn = 1'b0;
  endtask
  task automatic codeRd(input logic [15:0] a, output logic [7:0] r);
    @(posedge sys_clk) #1;
    codeRdEn = 1'b1;
    codeAddr = a;
    @(posedge sys_clk) #1;
    codeRdEn = 1'b0;
    r = codeRdData;
  endtask
  // Software polls busy before going on, bounded here
  task automatic waitIdle();
    n = 0;
    while (progBusy !== 1'b0 && n < 2000) begin
      @(posedge sys_clk) #1;
      n++;
    end
  endtask
  task automatic closeOut();
    $display("Checks %0d, mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {reset_n, sfrWrEn, sfrRdEn, xWrEn, codeRdEn, bootArraySelect} = '0;
    {sfrAddr, sfrWrData, xWrData, xAddr, codeAddr} = '0;
    repeat (3) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    sfrRd(FLASH_CTRL_ADDR, v);
    chk(v, FLASH_CTRL_RESET);
    sfrRd(8'hD2, v);
    chk(v, 8'h00);
    xWr(16'h0123, 8'h3C);
    chk({dmemWrEn, dmemAddr[6:0]}, 8'hA3);
    chk(dmemWrData, 8'h3C);
    // Two pages loaded; the later page must win
    sfrWr(FLASH_CTRL_ADDR, 8'h08);
    xWr(16'h0080, 8'h11);
    chk({7'h00, dmemWrEn}, 8'h00);
    xWr(16'h0105, 8'h55);
    sfrWr(FLASH_CTRL_ADDR, 8'h50);
    sfrWr(FLASH_CTRL_ADDR, 8'hA0);
    chk({6'h00, cpuIdleReq, progBusy}, 8'h03);
    // Clear attempt and a second key while busy
    sfrWr(FLASH_CTRL_ADDR, 8'h00);
    sfrRd(FLASH_CTRL_ADDR, v);
    chk(v, 8'h01);
    codeRd(16'h0100, v);
    chk(v, ERASED_BYTE);
    sfrWr(FLASH_CTRL_ADDR, 8'h50);
    // A first half taken while busy would arm the lone second half below
    waitIdle();
    chk({7'h00, n > 240 && n < 1000}, 8'h01);
    sfrWr(FLASH_CTRL_ADDR, 8'hA0);
    chk({7'h00, progBusy}, 8'h00);
    codeRd(16'h0100, v);
    chk(v, 8'h11);
    codeRd(16'h0105, v);
    chk(v, 8'h55);
    codeRd(16'h0200, v);
    chk(v, ERASED_BYTE);
    // One byte per space, then read back through its own mapping
    for (int i = 0; i < 3; i++) begin
      sfrWr(FLASH_CTRL_ADDR, ldMode[i]);
      xWr(ldAddr[i], ldData[i]);
      sfrWr(FLASH_CTRL_ADDR, {KEY_FIRST, ldMode[i][3:0]});
      sfrWr(FLASH_CTRL_ADDR, {KEY_SECOND, ldMode[i][3:0]});
      chk({7'h00, progBusy}, 8'h01);
      waitIdle();
      sfrWr(FLASH_CTRL_ADDR, ldMode[i] & 8'h06);
      codeRd(ldAddr[i], v);
      chk(v, expData[i]);
      codeRd(16'h0100, v);
      chk(v, rdOther[i]);
    end
    // Broken key, then the reserved space
    sfrWr(FLASH_CTRL_ADDR, 8'h50);
    sfrWr(FLASH_CTRL_ADDR, 8'h30);
    sfrWr(FLASH_CTRL_ADDR, 8'hA0);
    chk({7'h00, progBusy}, 8'h00);
    sfrWr(FLASH_CTRL_ADDR, 8'h56);
    sfrWr(FLASH_CTRL_ADDR, 8'hA6);
    chk({7'h00, progBusy}, 8'h00);
    // Boot array over the upper window only
    sfrWr(FLASH_CTRL_ADDR, 8'h00);
    bootArraySelect = 1'b1;
    codeRd(16'hF900, v);
    chk(v, 8'hA5);
    codeRd(16'hF7FF, v);
    chk(v, ERASED_BYTE);
    closeOut();
  end
endmodule
